// [verilog/tsec_pkg.sv]
// Purpose: Shared constants for the two-stage event controller
// Assumes: APB register map, one 32-bit word per register
// Notes: Assignment fields are 4 bits, eight per register
package tsec_pkg;
    localparam int CORE_W = 16;
    localparam int GP_LO = 7;
    localparam int NUM_GP = 9;
    localparam int NUM_SRC = 56;
    localparam int FIELD_W = 4;
    localparam int FIELDS_PER_REG = 8;
    localparam int NUM_ASSIGN = 7;
    localparam int ADDR_W = 8;
    localparam int EDGE_CYCLES = 2;
    localparam int MIN_PEND_CYCLES = 3;

    localparam logic [ADDR_W-1:0] OFS_CORE_LATCH = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CORE_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CORE_PEND = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL_EN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MASK_LO = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK_HI = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STAT_LO = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STAT_HI = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_WAKE_LO = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_WAKE_HI = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ASSIGN0 = 8'h30;

    localparam logic [CORE_W-1:0] RST_CORE_MASK = 16'h0000;
    localparam logic [31:0] RST_SYS_MASK = 32'h00000000;
    localparam logic [31:0] RST_WAKE = 32'h00000000;

    typedef enum logic [1:0] {TSEC_IDLE, TSEC_OFFER} tsec_offer_t;

    // Reset routing of each peripheral to a core input number
    function automatic logic [FIELD_W-1:0] tsec_def_assign(input int id);
        logic [FIELD_W-1:0] f;
        f = 4'h0;
        if (id >= 14 && id <= 15) f = 4'h1;
        else if (id >= 16 && id <= 19) f = 4'h2;
        else if ((id >= 20 && id <= 25) || (id >= 51 && id <= 55)) f = 4'h3;
        else if (id >= 26 && id <= 31) f = 4'h4;
        else if (id >= 32 && id <= 41) f = 4'h5;
        else if (id >= 42 && id <= 46) f = 4'h6;
        return f;
    endfunction
endpackage

// [verilog/tsec_top.sv]
// Purpose: Two-stage event controller, system routing stage and core event stage
// Assumes: Peripheral lines and pipeline handshakes synchronous to ref_clk
// Notes: Registers over APB; core registers need a privileged access
//
// The placing of the registers and register access over APB are this design's own decisions.
module tsec_top
    import tsec_pkg::*;
#(
    parameter int NSRC = tsec_pkg::NUM_SRC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tsec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSRC-1:0] periphIrq,
    input wire logic coreIdle,
    input wire logic globalIrqEnableInstr,
    input wire logic globalIrqDisableInstr,
    input wire logic eventAccept,
    input wire logic eventReturn,
    input wire logic [3:0] eventReturnLevel,
    output logic eventReq,
    output logic [3:0] eventLevel,
    output logic wakeReq,
    output logic [tsec_pkg::NUM_GP-1:0] sysAck
);
    import tsec_pkg::*;

    logic [CORE_W-1:0] coreEventLatch;
    logic [CORE_W-1:0] coreEventMask;
    logic [CORE_W-1:0] coreEventPending;
    logic globalEnable;
    logic [63:0] periphIrqMask;
    logic [63:0] periphWakeEnable;
    logic [63:0] periphIrqStatus;
    logic [FIELD_W-1:0] assignField [NUM_ASSIGN*FIELDS_PER_REG];
    logic [NUM_GP-1:0] gpSample;
    logic [NUM_GP-1:0] gpPrev;
    tsec_offer_t offerState;

    // APB decode
    wire access = psel & penable;
    wire done = access & pready;
    wire wrDone = done & pwrite;
    wire priv = pprot[0];
    wire isCore = (paddr == OFS_CORE_LATCH) | (paddr == OFS_CORE_MASK) |
                  (paddr == OFS_CORE_PEND) | (paddr == OFS_GLOBAL_EN);
    wire [ADDR_W-1:0] asgOfs = paddr - OFS_ASSIGN0;
    wire isAssign = (paddr >= OFS_ASSIGN0) && (asgOfs[1:0] == 2'b00) &&
                    (asgOfs[ADDR_W-1:2] < NUM_ASSIGN);
    wire [2:0] asgIdx = asgOfs[4:2];
    wire isSys = (paddr == OFS_MASK_LO) | (paddr == OFS_MASK_HI) |
                 (paddr == OFS_STAT_LO) | (paddr == OFS_STAT_HI) |
                 (paddr == OFS_WAKE_LO) | (paddr == OFS_WAKE_HI) | isAssign;
    wire badAccess = ~(isSys | (isCore & priv));
    wire coreWr = wrDone & priv;
    wire wrLatch = coreWr & (paddr == OFS_CORE_LATCH);
    wire wrMask = coreWr & (paddr == OFS_CORE_MASK);
    wire wrGlobal = coreWr & (paddr == OFS_GLOBAL_EN);
    wire wrMaskLo = wrDone & (paddr == OFS_MASK_LO);
    wire wrMaskHi = wrDone & (paddr == OFS_MASK_HI);
    wire wrWakeLo = wrDone & (paddr == OFS_WAKE_LO);
    wire wrWakeHi = wrDone & (paddr == OFS_WAKE_HI);
    wire wrAssign = wrDone & isAssign;

    // System stage: status, masking and routing
    wire [NSRC-1:0] maskedIrq = periphIrq & periphIrqMask[NSRC-1:0];
    wire [NSRC-1:0] wakeHit = periphIrq & periphWakeEnable[NSRC-1:0];
    logic [NUM_GP-1:0] gpLine;

    // Each core input ORs every peripheral assigned to it whose system mask bit is set
    genvar g;
    generate
        for (g = 0; g < NUM_GP; g++) begin : gRoute
            logic [NSRC-1:0] hit;
            for (genvar s = 0; s < NSRC; s++) begin : gSrc
                assign hit[s] = maskedIrq[s] & (assignField[s] == FIELD_W'(g));
            end
            assign gpLine[g] = |hit;
        end
    endgenerate

    // Core stage: edge detect over two cycles
    wire [NUM_GP-1:0] gpEdge = gpSample & ~gpPrev;
    wire [CORE_W-1:0] edgeBits = {gpEdge, {GP_LO{1'b0}}};

    // Highest-priority offer above everything currently active
    wire [CORE_W-1:0] eligible = coreEventLatch & coreEventMask &
                                 {{NUM_GP{globalEnable}}, {GP_LO{1'b0}}};
    logic [3:0] bestLevel;
    logic bestValid;
    logic [3:0] activeLevel;
    logic activeValid;
    always_comb begin
        bestLevel = 4'h0;
        bestValid = 1'b0;
        activeLevel = 4'hf;
        activeValid = 1'b0;
        for (int i = CORE_W - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                bestLevel = 4'(i);
                bestValid = 1'b1;
            end
            if (coreEventPending[i]) begin
                activeLevel = 4'(i);
                activeValid = 1'b1;
            end
        end
    end
    wire canNest = bestValid & (~activeValid | (bestLevel < activeLevel));
    wire takeEvent = (offerState == TSEC_OFFER) & eventAccept;

    // Pending and latch next values
    logic [CORE_W-1:0] next_pending;
    logic [CORE_W-1:0] next_latch;
    logic [CORE_W-1:0] setPend;
    logic [CORE_W-1:0] retPend;
    always_comb begin
        setPend = '0;
        retPend = '0;
        if (takeEvent) begin
            setPend[eventLevel] = 1'b1;
        end
        if (eventReturn) begin
            retPend[eventReturnLevel] = 1'b1;
        end
        next_pending = (coreEventPending & ~retPend) | setPend;
        next_latch = coreEventLatch;
        if (wrLatch) begin
            next_latch = (coreEventLatch & coreEventMask) |
                         (pwdata[CORE_W-1:0] & ~coreEventMask);
        end
        next_latch = (next_latch & ~setPend) | edgeBits;
    end

    // Register read mux
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h00000000;
        if (isAssign) begin
            for (int k = 0; k < FIELDS_PER_REG; k++) begin
                rdMux[k*FIELD_W +: FIELD_W] = assignField[asgIdx*FIELDS_PER_REG + k];
            end
        end
        case (paddr)
            OFS_CORE_LATCH: rdMux = {16'h0000, coreEventLatch};
            OFS_CORE_MASK: rdMux = {16'h0000, coreEventMask};
            OFS_CORE_PEND: rdMux = {16'h0000, coreEventPending};
            OFS_GLOBAL_EN: rdMux = {31'h00000000, globalEnable};
            OFS_MASK_LO: rdMux = periphIrqMask[31:0];
            OFS_MASK_HI: rdMux = periphIrqMask[63:32];
            OFS_STAT_LO: rdMux = periphIrqStatus[31:0];
            OFS_STAT_HI: rdMux = periphIrqStatus[63:32];
            OFS_WAKE_LO: rdMux = periphWakeEnable[31:0];
            OFS_WAKE_HI: rdMux = periphWakeEnable[63:32];
            default: rdMux = rdMux;
        endcase
        if (isCore & ~priv) begin
            rdMux = 32'h00000000;
        end
    end

    // APB answer one cycle into the access phase
    wire armAnswer = access & ~pready;
    wire armRead = armAnswer & ~pwrite;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else if (clkEn) begin
            pready <= armAnswer;
        end
    end

    // Refusal flag travels with the answer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pslverr <= armAnswer & badAccess;
        end
    end

    // Read data stands only in the answer cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (clkEn) begin
            prdata <= armRead ? rdMux : 32'h00000000;
        end
    end

    // System mask pair
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            periphIrqMask <= {RST_SYS_MASK, RST_SYS_MASK};
        end else if (clkEn) begin
            if (wrMaskLo) periphIrqMask[31:0] <= pwdata;
            if (wrMaskHi) periphIrqMask[63:32] <= pwdata;
        end
    end

    // System wake-enable pair
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            periphWakeEnable <= {RST_WAKE, RST_WAKE};
        end else if (clkEn) begin
            if (wrWakeLo) periphWakeEnable[31:0] <= pwdata;
            if (wrWakeHi) periphWakeEnable[63:32] <= pwdata;
        end
    end

    // Status follows the raw peripheral lines
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            periphIrqStatus <= 64'h0000000000000000;
        end else if (clkEn) begin
            periphIrqStatus <= 64'(periphIrq);
        end
    end

    // Wake request while the core idles
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wakeReq <= 1'b0;
        end else if (clkEn) begin
            wakeReq <= coreIdle & (|wakeHit);
        end
    end

    // Pending bits returned as acknowledgement
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sysAck <= '0;
        end else if (clkEn) begin
            sysAck <= coreEventPending[CORE_W-1:GP_LO];
        end
    end

    // Assignment fields, one per peripheral
    generate
        for (g = 0; g < NUM_ASSIGN*FIELDS_PER_REG; g++) begin : gAsg
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    assignField[g] <= tsec_def_assign(g);
                end else if (clkEn && wrAssign && asgIdx == 3'(g / FIELDS_PER_REG)) begin
                    assignField[g] <= pwdata[(g % FIELDS_PER_REG)*FIELD_W +: FIELD_W];
                end
            end
        end
    endgenerate

    // Core input sampler, two flops for edge detection
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gpSample <= '0;
            gpPrev <= '0;
        end else if (clkEn) begin
            gpSample <= gpLine;
            gpPrev <= gpSample;
        end
    end

    // Event latch register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coreEventLatch <= '0;
        end else if (clkEn) begin
            coreEventLatch <= next_latch;
        end
    end

    // Nested-pending register, hardware updated only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coreEventPending <= '0;
        end else if (clkEn) begin
            coreEventPending <= next_pending;
        end
    end

    // Core mask, supervisor writes only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coreEventMask <= RST_CORE_MASK;
        end else if (clkEn) begin
            if (wrMask) coreEventMask <= pwdata[CORE_W-1:0];
        end
    end

    // Global enable, enable wins over disable
    wire setGlobal = globalIrqEnableInstr | (wrGlobal & pwdata[0]);
    wire clrGlobal = globalIrqDisableInstr | (wrGlobal & ~pwdata[0]);
    wire next_global = setGlobal | (globalEnable & ~clrGlobal);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            globalEnable <= 1'b0;
        end else if (clkEn) begin
            globalEnable <= next_global;
        end
    end

    // Offer to pipeline, held until accepted or withdrawn
    wire loadOffer = (offerState == TSEC_IDLE) & canNest;
    wire dropOffer = eventAccept | ~canNest | (bestLevel != eventLevel);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            offerState <= TSEC_IDLE;
            eventReq <= 1'b0;
        end else if (clkEn) begin
            case (offerState)
                TSEC_IDLE: begin
                    if (canNest) begin
                        offerState <= TSEC_OFFER;
                        eventReq <= 1'b1;
                    end
                end
                TSEC_OFFER: begin
                    if (dropOffer) begin
                        offerState <= TSEC_IDLE;
                        eventReq <= 1'b0;
                    end
                end
                default: begin
                    offerState <= TSEC_IDLE;
                    eventReq <= 1'b0;
                end
            endcase
        end
    end

    // Offered level loads with each new offer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eventLevel <= 4'h0;
        end else if (clkEn && loadOffer) begin
            eventLevel <= bestLevel;
        end
    end
endmodule

// [tb/tsec_top_chk.sv]
// Purpose: Port checker for the two-stage event controller
// Assumes: One clock ref_clk, synchronous reset sys_rst, clkEn held high
// Notes: Bound into tsec_top below
module tsec_top_chk
    import tsec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [tsec_pkg::ADDR_W-1:0] paddr,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    input wire logic coreIdle,
    input wire logic globalIrqEnableInstr,
    input wire logic globalIrqDisableInstr,
    input wire logic eventAccept,
    input wire logic eventReq,
    input wire logic wakeReq,
    input wire logic [3:0] eventLevel,
    input wire logic [tsec_pkg::NUM_GP-1:0] sysAck
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_ack;
        logic [3:0] lv;
        (eventReq && eventAccept, lv = eventLevel) |-> ##2 sysAck[lv - 4'd7];
    endproperty
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_wake_idle: assert property (wakeReq |-> $past(coreIdle))
        else $error("wake request without idle core");
    a_accept_drop: assert property (eventReq && eventAccept |=> !eventReq)
        else $error("offer stayed after acceptance");
    a_level_range: assert property (eventReq |-> eventLevel >= 4'd7)
        else $error("offered level below seven");
    a_ack_follow: assert property (p_ack)
        else $error("acknowledge bit missing after acceptance");
    a_global_off: assert property (
        globalIrqDisableInstr && !globalIrqEnableInstr |-> ##3 !eventReq)
        else $error("offer while globally disabled");
    a_core_priv: assert property (
        psel && penable && pready && paddr == OFS_CORE_MASK && !pprot[0] |-> pslverr)
        else $error("unprivileged mask access accepted");
    a_refuse_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    c_accept: cover property (eventReq && eventAccept);
    c_wake: cover property (wakeReq);
    c_refuse: cover property (pready && pslverr);
endmodule

bind tsec_top tsec_top_chk tsec_top_chk_inst (.ref_clk, .sys_rst, .psel, .penable,
    .pwrite, .pready, .pslverr, .paddr, .pprot, .prdata, .coreIdle,
    .globalIrqEnableInstr, .globalIrqDisableInstr, .eventAccept, .eventReq,
    .wakeReq, .eventLevel, .sysAck);

// [tb/tsec_pipe_model.sv]
// Purpose: Pipeline side model, accepts offers and returns from service
// Assumes: Offers are registered levels 7..15
// Notes: hold stalls both acceptance and return
module tsec_pipe_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hold,
    input wire logic eventReq,
    input wire logic [3:0] eventLevel,
    output logic eventAccept,
    output logic eventReturn,
    output logic [3:0] eventReturnLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] active;
    logic [3:0] svcCnt;
    logic [3:0] lowest;
    always_comb begin
        lowest = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (active[i]) lowest = 4'(i);
        end
    end
    always_ff @(posedge ref_clk) begin
        eventAccept <= 1'b0;
        eventReturn <= 1'b0;
        if (sys_rst) begin
            active <= '0;
            svcCnt <= '0;
            eventReturnLevel <= '0;
        end else if (eventReq && !eventAccept && !hold) begin
            eventAccept <= 1'b1;
            active[eventLevel] <= 1'b1;
            svcCnt <= '0;
        end else if (active != '0 && !hold) begin
            svcCnt <= svcCnt + 4'h1;
            if (svcCnt == 4'h7) begin
                eventReturn <= 1'b1;
                eventReturnLevel <= lowest;
                active[lowest] <= 1'b0;
                svcCnt <= '0;
            end
        end
    end
endmodule

// [tb/two_stage_event_controller_test.sv]
// Purpose: Self-checking bench for the two-stage event controller
// Assumes: APB master with one wait state answers, pipeline model on far side
// Notes: clkEn tied high
module two_stage_event_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tsec_pkg::*;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, coreIdle = 0;
    logic globalIrqEnableInstr = 0, globalIrqDisableInstr = 0, hold = 1;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [2:0] pprot = 3'h1;
    logic [55:0] periphIrq = '0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, eventReq, wakeReq, eventAccept, eventReturn;
    wire logic [3:0] eventLevel, eventReturnLevel;
    wire logic [8:0] sysAck;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    logic [31:0] rd;
    logic err;
    int n;
    always #2 ref_clk = ~ref_clk;
    tsec_top tsec_top_inst (.ref_clk, .sys_rst, .clkEn(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pprot, .prdata, .pready, .pslverr, .periphIrq, .coreIdle,
        .globalIrqEnableInstr, .globalIrqDisableInstr, .eventAccept, .eventReturn,
        .eventReturnLevel, .eventReq, .eventLevel, .wakeReq, .sysAck);
    tsec_pipe_model tsec_pipe_model_inst (.ref_clk, .sys_rst, .hold, .eventReq,
        .eventLevel, .eventAccept, .eventReturn, .eventReturnLevel);
    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            $display("FAIL %0t run too long", $time);
            test_done();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [2:0] pr);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= pr;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++k < 20);
        if (k == 20) begin
            mismatches++;
            $display("FAIL %0t no bus answer", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 3'h1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 3'h1);
        check(rd, exp);
    endtask
    task automatic waitReq();
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (eventReq !== 1'b1 && n < 20);
        check(eventReq, 1'b1);
    endtask
    task automatic t_regs();
        rchk(OFS_MASK_LO, 32'h0);
        rchk(OFS_WAKE_HI, 32'h0);
        rchk(OFS_ASSIGN0 + 8'h04, 32'h11000000);
        rchk(OFS_ASSIGN0 + 8'h0c, 32'h44444433);
        rchk(OFS_ASSIGN0 + 8'h14, 32'h06666655);
        rchk(OFS_ASSIGN0 + 8'h18, 32'h33333000);
        wr(OFS_MASK_HI, 32'h00ffffff);
        rchk(OFS_MASK_HI, 32'h00ffffff);
        wr(OFS_STAT_LO, 32'hffffffff);
        rchk(OFS_STAT_LO, 32'h0);
        apb(1'b0, 8'h2c, 32'h0, 3'h1);
        check(err, 1'b1);
        apb(1'b1, OFS_CORE_MASK, 32'h0400, 3'h0);
        check(err, 1'b1);
        rchk(OFS_CORE_MASK, 32'h0);
    endtask
    task automatic t_event();
        wr(OFS_MASK_LO, 32'h00b00000);
        wr(OFS_CORE_MASK, 32'h0400);
        wr(OFS_GLOBAL_EN, 32'h1);
        periphIrq[20] <= 1'b1;
        waitReq();
        check(n >= 3, 1'b1);
        check(eventLevel, 4'ha);
        rchk(OFS_CORE_LATCH, 32'h0400);
        rchk(OFS_STAT_LO, 32'h00100000);
        hold <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (sysAck[3] !== 1'b1 && n < 20);
        hold <= 1'b1;
        check(sysAck[3], 1'b1);
        periphIrq[20] <= 1'b0;
        @(posedge ref_clk);
        periphIrq[20] <= 1'b1;
        rchk(OFS_CORE_LATCH, 32'h0400);
        check(eventReq, 1'b0);
        rchk(OFS_CORE_PEND, 32'h0400);
        hold <= 1'b0;
        periphIrq[20] <= 1'b0;
        repeat (40) @(posedge ref_clk);
        rchk(OFS_CORE_LATCH, 32'h0);
    endtask
    task automatic t_mask();
        hold <= 1'b1;
        periphIrq[22] <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(eventReq, 1'b0);
        wr(OFS_CORE_MASK, 32'h0);
        periphIrq[21] <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(eventReq, 1'b0);
        rchk(OFS_CORE_LATCH, 32'h0400);
        wr(OFS_CORE_LATCH, 32'h0);
        rchk(OFS_CORE_LATCH, 32'h0);
        wr(OFS_CORE_LATCH, 32'h0400);
        wr(OFS_CORE_MASK, 32'h0400);
        waitReq();
        check(eventReq, 1'b1);
        hold <= 1'b0;
        periphIrq[22:21] <= 2'b00;
        repeat (40) @(posedge ref_clk);
    endtask
    task automatic t_global();
        hold <= 1'b1;
        globalIrqDisableInstr <= 1'b1;
        @(posedge ref_clk);
        globalIrqDisableInstr <= 1'b0;
        periphIrq[23:21] <= 3'b101;
        repeat (10) @(posedge ref_clk);
        check(eventReq, 1'b0);
        rchk(OFS_STAT_LO, 32'h00a00000);
        globalIrqEnableInstr <= 1'b1;
        @(posedge ref_clk);
        globalIrqEnableInstr <= 1'b0;
        waitReq();
        check(eventLevel, 4'ha);
        hold <= 1'b0;
        periphIrq[23:21] <= 3'b000;
        repeat (40) @(posedge ref_clk);
    endtask
    task automatic t_wake_route();
        wr(OFS_WAKE_LO, 32'h00100000);
        coreIdle <= 1'b1;
        periphIrq[20] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(wakeReq, 1'b1);
        coreIdle <= 1'b0;
        periphIrq[20] <= 1'b0;
        repeat (40) @(posedge ref_clk);
        check(wakeReq, 1'b0);
        wr(OFS_ASSIGN0 + 8'h08, 32'h33362222);
        rchk(OFS_ASSIGN0 + 8'h08, 32'h33362222);
        wr(OFS_CORE_MASK, 32'h2000);
        periphIrq[20] <= 1'b1;
        waitReq();
        check(eventLevel, 4'hd);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_event();
        t_mask();
        t_global();
        t_wake_route();
        test_done();
    end
endmodule
